// file: hdl/msc_regs.svh
// constants for the modem system control sequencer and its host controller
// What this block does
// - card stays off while power pin low
// - restart input acts without any clock
// - restart asserted holds power-on reset state
// - host restarts only after critical failure; here the restart control bit asserts it, with no failure check
// - host raises power after supply valid; here the power control bit raises it, with no supply check
// - host releases restart after power high
// - double enumeration: connect within one second
// - single enumeration: connect within ten seconds
// - power-off sequence done within twenty seconds
// - shutdown may take ten more seconds
// - forced cycle: power low over 500 ms
// - after forced cycle repeat power-up sequence
// - host waits ninety seconds after soft reboot; no such wait is timed here, MSC_REBOOT_MS is unused
// - cellular inhibit low blocks cellular transmit
// - positioning inhibit low disables positioning radio
// - software command also disables each radio
// - status lamp low while radio can transmit
// - wake host with one-second low pulse
// - host pulls wake line up
`ifndef MSC_REGS_SVH
`define MSC_REGS_SVH
`define MSC_CLK_MHZ            100
// times in milliseconds
`define MSC_DBL_ENUM_MS        589
`define MSC_SGL_ENUM_MS        7772
`define MSC_USB_QUIET_MS       7146
`define MSC_SHUTDOWN_MS        10000
`define MSC_FORCE_OFF_MS       501
`define MSC_WAKE_MS            1000
`define MSC_REBOOT_MS          90000
`define MSC_STEP_MS            1
// host step between power and restart release, in cycles
`define MSC_HOST_STEP_CYC      ((`MSC_STEP_MS * 1000 * `MSC_CLK_MHZ))
// cycles per millisecond
`define MSC_MS_CYC             (1000 * `MSC_CLK_MHZ)
// apb register offsets of the host controller
`define MSC_CTRL_OFS           12'h000
`define MSC_STAT_OFS           12'h004
// control fields
`define MSC_CTRL_POWER_BIT     0
`define MSC_CTRL_FORCE_BIT     1
`define MSC_CTRL_RESTART_BIT   2
`define MSC_CTRL_CELL_BIT      3
`define MSC_CTRL_GNSS_BIT      4
`define MSC_CTRL_RESET_VAL     32'h0000_0000
// status fields
`define MSC_STAT_STATE_LSB     0
`define MSC_STAT_LAMP_BIT      4
`define MSC_STAT_WAKE_BIT      5
`define MSC_STAT_BUSY_BIT      6
`endif

// file: hdl/msc_pkg.sv
// types shared by both ends of the system control link
package msc_pkg;
  // device power sequence states
  typedef enum logic [2:0] {
    MSC_OFF,
    MSC_POR,
    MSC_BOOT,
    MSC_ON,
    MSC_USB_QUIET,
    MSC_SHUTDOWN
  } msc_dev_state_t;
  // host controller states
  typedef enum logic [2:0] {
    MSC_H_IDLE,
    MSC_H_PWR_UP,
    MSC_H_RUN,
    MSC_H_FORCE_LOW,
    MSC_H_OFF
  } msc_host_state_t;
endpackage : msc_pkg

// file: hdl/msc_link_if.sv
// pins between host platform and modem card
`timescale 1ns/100ps
interface msc_link_if;
  logic card_power;        // card power control, high = on
  logic restart_n;         // hard restart, active low
  logic cell_inhibit_n;    // cellular transmit inhibit
  logic gnss_inhibit_n;    // positioning inhibit
  logic lamp_o;            // open-drain lamp, device side
  logic lamp_oe;
  logic wake_o;            // open-drain wake, device side
  logic wake_oe;
  logic radio_status_lamp_n;
  logic host_wake_n;
  // open-drain resolution with pull-ups
  assign radio_status_lamp_n = lamp_oe ? lamp_o : 1'b1;
  assign host_wake_n         = wake_oe ? wake_o : 1'b1;
  modport device (
    input  card_power, restart_n, cell_inhibit_n, gnss_inhibit_n,
    output lamp_o, lamp_oe, wake_o, wake_oe
  );
  modport host (
    output card_power, restart_n, cell_inhibit_n, gnss_inhibit_n,
    input  radio_status_lamp_n, host_wake_n
  );
endinterface : msc_link_if

// file: hdl/msc_device.sv
// modem card end: power sequencer, radio gating, lamp and wake
`timescale 1ns/100ps
`include "msc_regs.svh"
module msc_device
  import msc_pkg::*;
#(
  parameter int unsigned P_DBL_CYC   = `MSC_DBL_ENUM_MS * `MSC_MS_CYC,
  parameter int unsigned P_SGL_CYC   = `MSC_SGL_ENUM_MS * `MSC_MS_CYC,
  parameter int unsigned P_QUIET_CYC = `MSC_USB_QUIET_MS * `MSC_MS_CYC,
  parameter int unsigned P_SHUT_CYC  = `MSC_SHUTDOWN_MS * `MSC_MS_CYC,
  parameter int unsigned P_WAKE_CYC  = `MSC_WAKE_MS * `MSC_MS_CYC
) (
  // clock and reset
  input  wire logic   i_sys_clk,
  input  wire logic   i_reset,
  // link pins
  msc_link_if.device  link,
  // card firmware side
  input  wire logic   i_single_enum,
  input  wire logic   i_sw_cell_off,
  input  wire logic   i_sw_gnss_off,
  input  wire logic   i_wake_req,
  output logic        o_usb_connect,
  output logic        o_cell_tx_en,
  output logic        o_gnss_en,
  output logic        o_powered,
  output logic [2:0]  o_state
);
  msc_dev_state_t state_q;
  logic [31:0]    cnt_q;
  logic [3:0]     sync1_q;
  logic [3:0]     sync2_q;
  logic           pwr_s;
  logic           cell_s;
  logic           gnss_s;
  logic           rst_n_s;
  logic           hard_rst;
  logic [31:0]    boot_lim;
  logic           wake_busy_q;
  logic [31:0]    wake_cnt_q;
  logic           lamp_q;
  logic           run_s;

  // restart acts asynchronously alongside the system reset
  assign hard_rst = i_reset | ~link.restart_n;

  // first sync stage; nothing but stage two reads it
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1_q <= 4'h0;
    end else begin
      sync1_q <= {link.restart_n, link.gnss_inhibit_n,
                  link.cell_inhibit_n, link.card_power};
    end
  end

  // second sync stage; the only copy the sequencer and gating read
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      sync2_q <= 4'h0;
    end else begin
      sync2_q <= sync1_q;
    end
  end
  assign pwr_s   = sync2_q[0];
  assign cell_s  = sync2_q[1];
  assign gnss_s  = sync2_q[2];
  assign rst_n_s = sync2_q[3];

  // boot time picked by enumeration mode; the pin is static in use
  assign boot_lim = i_single_enum ? P_SGL_CYC : P_DBL_CYC;

  // running state decoded once; gating, wake and usb all key off it
  assign run_s = (state_q == MSC_ON);

  // power sequencer; restart forces the power-on reset state at once
  // a card power pulse that spans no rising clock edge is not seen at all;
  // the host holds its levels for many cycles, so nothing is lost
  // counts reach about a billion at most and fit the 32-bit counter
  always_ff @(posedge i_sys_clk or posedge hard_rst) begin
    if (hard_rst) begin
      state_q <= MSC_POR;
      cnt_q   <= 32'h0000_0000;
    end else begin
      case (state_q)
        // card unpowered; boot starts once power is seen high
        MSC_OFF: begin
          cnt_q <= 32'h0000_0000;
          if (pwr_s) begin
            state_q <= MSC_BOOT;
          end
        end
        MSC_POR: begin
          cnt_q <= 32'h0000_0000;
          // wait until restart is seen released after sync
          if (rst_n_s) begin
            state_q <= pwr_s ? MSC_BOOT : MSC_OFF;
          end
        end
        // booting; power loss here aborts straight to off
        MSC_BOOT: begin
          if (!pwr_s) begin
            state_q <= MSC_OFF;
            cnt_q   <= 32'h0000_0000;
          end else if (cnt_q >= boot_lim - 32'h0000_0001) begin
            state_q <= MSC_ON;
            cnt_q   <= 32'h0000_0000;
          end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
          end
        end
        // running; power loss starts the orderly shutdown
        MSC_ON: begin
          cnt_q <= 32'h0000_0000;
          if (!pwr_s) begin
            state_q <= MSC_USB_QUIET;
          end
        end
        MSC_USB_QUIET: begin
          // traffic winds down; the sequence completes even if power
          // returns, the card then boots again from off
          if (cnt_q >= P_QUIET_CYC - 32'h0000_0001) begin
            state_q <= MSC_SHUTDOWN;
            cnt_q   <= 32'h0000_0000;
          end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
          end
        end
        // final shutdown stretch before the card is off
        MSC_SHUTDOWN: begin
          if (cnt_q >= P_SHUT_CYC - 32'h0000_0001) begin
            state_q <= MSC_OFF;
            cnt_q   <= 32'h0000_0000;
          end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
          end
        end
        default: begin
          state_q <= MSC_POR;
          cnt_q   <= 32'h0000_0000;
        end
      endcase
    end
  end

  // cellular transmit gate: pin and software must both allow it
  always_ff @(posedge i_sys_clk or posedge hard_rst) begin
    if (hard_rst) begin
      o_cell_tx_en <= 1'b0;
    end else begin
      o_cell_tx_en <= run_s & cell_s & ~i_sw_cell_off;
    end
  end

  // positioning gate: same pair of controls, its own pin
  always_ff @(posedge i_sys_clk or posedge hard_rst) begin
    if (hard_rst) begin
      o_gnss_en <= 1'b0;
    end else begin
      o_gnss_en <= run_s & gnss_s & ~i_sw_gnss_off;
    end
  end

  // lamp mirrors the cellular gate; it shows transmit capability, not
  // traffic, so a lit lamp does not mean the radio is sending
  always_ff @(posedge i_sys_clk or posedge hard_rst) begin
    if (hard_rst) begin
      lamp_q <= 1'b0;
    end else begin
      lamp_q <= run_s & cell_s & ~i_sw_cell_off;
    end
  end

  // single wake pulse; requests during a pulse are dropped, so a burst
  // of requests still gives the host one clean pulse to count
  always_ff @(posedge i_sys_clk or posedge hard_rst) begin
    if (hard_rst) begin
      wake_busy_q <= 1'b0;
    end else if (wake_busy_q) begin
      if (wake_cnt_q >= P_WAKE_CYC - 32'h0000_0001) begin
        wake_busy_q <= 1'b0;
      end
    end else if (i_wake_req && run_s) begin
      wake_busy_q <= 1'b1;
    end
  end

  // pulse length counter; parked at zero between pulses
  always_ff @(posedge i_sys_clk or posedge hard_rst) begin
    if (hard_rst) begin
      wake_cnt_q <= 32'h0000_0000;
    end else if (!wake_busy_q) begin
      wake_cnt_q <= 32'h0000_0000;
    end else if (wake_cnt_q >= P_WAKE_CYC - 32'h0000_0001) begin
      wake_cnt_q <= 32'h0000_0000;
    end else begin
      wake_cnt_q <= wake_cnt_q + 32'h0000_0001;
    end
  end

  // open drain: drive low only, otherwise release
  assign link.lamp_o  = 1'b0;
  assign link.lamp_oe = lamp_q;
  assign link.wake_o  = 1'b0;
  assign link.wake_oe = wake_busy_q;

  // status for the card firmware, decoded from the state register
  assign o_usb_connect = run_s;
  assign o_powered     = (state_q != MSC_OFF) && (state_q != MSC_POR);
  assign o_state       = state_q;
endmodule : msc_device

// file: hdl/msc_host.sv
// host platform end: apb-controlled power, restart and inhibit pins
`timescale 1ns/100ps
`include "msc_regs.svh"
module msc_host
  import msc_pkg::*;
#(
  parameter int unsigned P_FORCE_CYC = `MSC_FORCE_OFF_MS * `MSC_MS_CYC,
  parameter int unsigned P_STEP_CYC  = `MSC_HOST_STEP_CYC
) (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic [31:0]      o_prdata,
  // link pins
  msc_link_if.host         link
);
  msc_host_state_t st_q;
  logic [31:0]     ctrl_q;
  logic [31:0]     cnt_q;
  logic            wr;
  logic            force_go;
  logic            hit;

  assign hit      = (i_paddr == `MSC_CTRL_OFS) || (i_paddr == `MSC_STAT_OFS);
  assign wr       = i_psel & i_penable & i_pwrite;
  assign force_go = wr && (i_paddr == `MSC_CTRL_OFS)
                    && i_pwdata[`MSC_CTRL_FORCE_BIT];
  // zero-wait slave; unmapped addresses answer with an error
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~hit;

  // control register; force bit self-clears when the cycle ends
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_q <= `MSC_CTRL_RESET_VAL;
    end else if (wr && i_paddr == `MSC_CTRL_OFS) begin
      ctrl_q <= i_pwdata;
    end else if (st_q == MSC_H_RUN || st_q == MSC_H_OFF) begin
      ctrl_q[`MSC_CTRL_FORCE_BIT] <= 1'b0;
    end
  end

  // read mux registered for the access phase
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      if (i_paddr == `MSC_CTRL_OFS) begin
        o_prdata <= ctrl_q;
      end else if (i_paddr == `MSC_STAT_OFS) begin
        o_prdata <= {25'h000_0000, st_q != MSC_H_RUN && st_q != MSC_H_OFF
                     && st_q != MSC_H_IDLE, link.host_wake_n,
                     link.radio_status_lamp_n, 1'b0, st_q};
      end else begin
        o_prdata <= 32'h0000_0000;
      end
    end
  end

  // pin sequencer: power then restart release, forced cycle
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      st_q  <= MSC_H_IDLE;
      cnt_q <= 32'h0000_0000;
    end else begin
      case (st_q)
        MSC_H_IDLE: begin
          cnt_q <= 32'h0000_0000;
          if (ctrl_q[`MSC_CTRL_POWER_BIT]) begin
            st_q <= MSC_H_PWR_UP;
          end
        end
        MSC_H_PWR_UP: begin
          if (cnt_q >= P_STEP_CYC - 32'h0000_0001) begin
            st_q  <= MSC_H_RUN;
            cnt_q <= 32'h0000_0000;
          end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
          end
        end
        MSC_H_RUN: begin
          cnt_q <= 32'h0000_0000;
          if (force_go) begin
            st_q <= MSC_H_FORCE_LOW;
          end else if (!ctrl_q[`MSC_CTRL_POWER_BIT]) begin
            st_q <= MSC_H_OFF;
          end
        end
        MSC_H_FORCE_LOW: begin
          // held strictly longer than the minimum, then power again
          if (cnt_q >= P_FORCE_CYC - 32'h0000_0001) begin
            st_q  <= MSC_H_PWR_UP;
            cnt_q <= 32'h0000_0000;
          end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
          end
        end
        MSC_H_OFF: begin
          cnt_q <= 32'h0000_0000;
          if (ctrl_q[`MSC_CTRL_POWER_BIT]) begin
            st_q <= MSC_H_PWR_UP;
          end
        end
        default: begin
          st_q <= MSC_H_IDLE;
        end
      endcase
    end
  end

  // pins from state; restart held low outside run and off, and whenever the restart bit is set
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      link.card_power     <= 1'b0;
      link.restart_n      <= 1'b0;
      link.cell_inhibit_n <= 1'b1;
      link.gnss_inhibit_n <= 1'b1;
    end else begin
      link.card_power <= (st_q == MSC_H_PWR_UP) || (st_q == MSC_H_RUN);
      // left released when power goes off so the card can finish its
      // orderly shutdown; it may fall there but never rise
      link.restart_n  <= ((st_q == MSC_H_RUN)
                          || (st_q == MSC_H_OFF && link.restart_n))
                         && !ctrl_q[`MSC_CTRL_RESTART_BIT];
      link.cell_inhibit_n <= !ctrl_q[`MSC_CTRL_CELL_BIT];
      link.gnss_inhibit_n <= !ctrl_q[`MSC_CTRL_GNSS_BIT];
    end
  end
endmodule : msc_host

// file: verif/msc_properties.sv
// checker for the pins between host and modem card
`timescale 1ns/100ps
module msc_properties #(
  parameter int unsigned P_WAKE_CYC = 8
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // link signals
  input wire logic card_power,
  input wire logic restart_n,
  input wire logic cell_inhibit_n,
  input wire logic lamp_o,
  input wire logic lamp_oe,
  input wire logic wake_o,
  input wire logic wake_oe,
  input wire logic radio_status_lamp_n,
  input wire logic host_wake_n
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  logic [31:0] wake_cnt_q;
  // counts a wake pulse so its length can be judged when it ends
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) wake_cnt_q <= '0;
    else if (wake_oe) wake_cnt_q <= wake_cnt_q + 32'h0000_0001;
    else wake_cnt_q <= '0;
  end
  // six samples leave room for the two sync flops and the lamp register
  sequence s_inhibit_held; !cell_inhibit_n [*6]; endsequence
  sequence s_restart_held; !restart_n ##1 !restart_n; endsequence
  sequence s_wake_end; $fell(wake_oe); endsequence
  property p_restart_after_power;
    $rose(restart_n) |-> card_power && $past(card_power);
  endproperty
  property p_lamp_open_drain; lamp_oe |-> !lamp_o; endproperty
  property p_wake_open_drain; wake_oe |-> !wake_o; endproperty
  property p_wake_len; s_wake_end |-> wake_cnt_q == P_WAKE_CYC; endproperty
  property p_inhibit_lamp; s_inhibit_held |-> !lamp_oe; endproperty
  property p_restart_quiet; s_restart_held |-> !lamp_oe && !wake_oe;
  endproperty
  property p_lamp_wire; radio_status_lamp_n == !lamp_oe; endproperty
  property p_wake_wire; host_wake_n == !wake_oe; endproperty
  a_restart_after_power: assert property (p_restart_after_power)
    else $error("restart released without power high");
  a_lamp_open_drain: assert property (p_lamp_open_drain)
    else $error("lamp driven high");
  a_wake_open_drain: assert property (p_wake_open_drain)
    else $error("wake driven high");
  a_wake_len: assert property (p_wake_len)
    else $error("wake pulse length wrong");
  a_inhibit_lamp: assert property (p_inhibit_lamp)
    else $error("lamp lit while cellular inhibited");
  a_restart_quiet: assert property (p_restart_quiet)
    else $error("outputs active during restart");
  a_lamp_wire: assert property (p_lamp_wire)
    else $error("lamp line level wrong");
  a_wake_wire: assert property (p_wake_wire)
    else $error("wake line level wrong");
endmodule : msc_properties

// file: verif/tb.sv
// self-checking bench for host and card ends joined by the link
`timescale 1ns/100ps
module tb;
  import msc_pkg::*;
  localparam int DBL = 20, SGL = 40, QS = 20, WAKE = 8, FRC = 10;
  logic i_sys_clk, i_reset, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic single_enum, sw_cell, sw_gnss, wake_req, usb, cell_en, gnss_en;
  logic powered;
  logic [2:0] state;
  int fails, tests_run, n;
  msc_link_if link ();
  msc_host #(.P_FORCE_CYC(FRC), .P_STEP_CYC(3)) msc_host_inst (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_prdata(prdata), .link(link.host));
  msc_device #(.P_DBL_CYC(DBL), .P_SGL_CYC(SGL), .P_QUIET_CYC(10),
    .P_SHUT_CYC(10), .P_WAKE_CYC(WAKE)) msc_device_inst (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .link(link.device),
    .i_single_enum(single_enum), .i_sw_cell_off(sw_cell),
    .i_sw_gnss_off(sw_gnss), .i_wake_req(wake_req), .o_usb_connect(usb),
    .o_cell_tx_en(cell_en), .o_gnss_en(gnss_en), .o_powered(powered),
    .o_state(state));
  msc_properties #(.P_WAKE_CYC(WAKE)) msc_properties_inst (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .card_power(link.card_power), .restart_n(link.restart_n),
    .cell_inhibit_n(link.cell_inhibit_n), .lamp_o(link.lamp_o),
    .lamp_oe(link.lamp_oe), .wake_o(link.wake_o), .wake_oe(link.wake_oe),
    .radio_status_lamp_n(link.radio_status_lamp_n),
    .host_wake_n(link.host_wake_n));
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  // one apb transfer; holds the request until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge i_sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge i_sys_clk);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin fails++; report_and_stop(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // bounded wait for a card state; n holds the cycles taken minus one
  task wait_state(input logic [2:0] s);
    for (n = 0; n < 3000; n++) begin
      @(posedge i_sys_clk);
      if (state === s) return;
    end
    fails++;
    report_and_stop();
  endtask : wait_state
  task t_reset;
    apb(1'b0, 12'h000, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check(link.card_power, 1'b0);
    check(state, MSC_POR);
    check(powered, 1'b0);
    apb(1'b0, 12'h004, 32'h0000_0000);
    check(rd, 32'h0000_0030);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check(err, 1'b1);
    check(rd, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset
  task t_power_up(input logic single);
    single_enum <= single;
    apb(1'b1, 12'h000, 32'h0000_0001);
    wait_state(MSC_BOOT);
    wait_state(MSC_ON);
    check(n + 1, single ? SGL : DBL);
    check(usb, 1'b1);
    check({link.card_power, powered}, 2'b11);
    check(link.restart_n, 1'b1);
    $display("test power up done");
  endtask : t_power_up
  task t_radio;
    repeat (4) @(posedge i_sys_clk);
    check({link.radio_status_lamp_n, cell_en, gnss_en}, 3'b011);
    apb(1'b1, 12'h000, 32'h0000_0019);
    repeat (6) @(posedge i_sys_clk);
    check(link.cell_inhibit_n, 1'b0);
    check({link.radio_status_lamp_n, cell_en, gnss_en}, 3'b100);
    apb(1'b1, 12'h000, 32'h0000_0001);
    sw_cell <= 1'b1; sw_gnss <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
    check({link.radio_status_lamp_n, cell_en, gnss_en}, 3'b100);
    sw_cell <= 1'b0; sw_gnss <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
    check({link.radio_status_lamp_n, cell_en, gnss_en}, 3'b011);
    $display("test radio done");
  endtask : t_radio
  task t_wake;
    wake_req <= 1'b1;
    @(posedge i_sys_clk);
    wake_req <= 1'b0;
    for (n = 0; n < 20 && link.host_wake_n !== 1'b0; n++)
      @(posedge i_sys_clk);
    for (n = 0; n < 50 && link.host_wake_n === 1'b0; n++)
      @(posedge i_sys_clk);
    check(n, WAKE);
    $display("test wake done");
  endtask : t_wake
  // forced cycle: power held low for the set count, then a full boot
  task t_force;
    apb(1'b1, 12'h000, 32'h0000_0003);
    for (n = 0; n < 20 && link.card_power !== 1'b0; n++)
      @(posedge i_sys_clk);
    for (n = 0; n < 50 && link.card_power === 1'b0; n++)
      @(posedge i_sys_clk);
    check(n, FRC);
    wait_state(MSC_BOOT);
    wait_state(MSC_ON);
    check(n + 1, DBL);
    $display("test force done");
  endtask : t_force
  task t_power_off;
    apb(1'b1, 12'h000, 32'h0000_0000);
    wait_state(MSC_USB_QUIET);
    check(link.restart_n, 1'b1);
    wait_state(MSC_OFF);
    check(n + 1, QS);
    check({usb, link.radio_status_lamp_n}, 2'b01);
    $display("test power off done");
  endtask : t_power_off
  task t_restart;
    apb(1'b1, 12'h000, 32'h0000_0005);
    wait_state(MSC_POR);
    repeat (3) @(posedge i_sys_clk);
    check(state, MSC_POR);
    check({usb, link.radio_status_lamp_n}, 2'b01);
    apb(1'b1, 12'h000, 32'h0000_0001);
    wait_state(MSC_BOOT);
    check(link.restart_n, 1'b1);
    wait_state(MSC_ON);
    check(usb, 1'b1);
    $display("test restart done");
  endtask : t_restart
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0000_0000; single_enum = 1'b0;
    sw_cell = 1'b0; sw_gnss = 1'b0; wake_req = 1'b0;
    fails = 0; tests_run = 0; i_reset = 1'b1;
    repeat (5) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    t_reset();
    t_power_up(1'b0);
    t_radio();
    t_wake();
    t_force();
    t_power_off();
    t_power_up(1'b1);
    t_restart();
    report_and_stop();
  end
endmodule : tb
